// ---- common/csc_pkg.sv ----
// constants, types and register map of the clock source and start-up control
// assumes one system clock; option bits arrive from the non-volatile store
`default_nettype none

package csc_pkg;

    // counter width for the longest settling count
    localparam int unsigned CNT_W = 17;

    // start-up counts
    localparam int unsigned CK_RESET_SRC      = 14;
    localparam int unsigned CK_WAKE_RC_EXT    = 6;
    localparam int unsigned CK_WAKE_258       = 258;
    localparam int unsigned CK_WAKE_1K        = 1024;
    localparam int unsigned CK_WAKE_16K       = 16384;
    localparam int unsigned CK_WAKE_32K       = 32768;
    localparam int unsigned WDT_SHORT_CYCLES  = 4096;
    localparam int unsigned WDT_LONG_CYCLES   = 65536;
    localparam int unsigned PRESCALE_DIV8_TOP = 7;

    // option codes, stored sense
    localparam logic [3:0] SEL_RC           = 4'h2;
    localparam logic [3:0] SEL_EXT          = 4'h0;
    localparam logic [3:0] SEL_LOWFREQ_FAST = 4'h6;
    localparam logic [3:0] SEL_LOWFREQ_SLOW = 4'h7;

    // factory option values
    localparam logic [3:0] FACTORY_CLOCK_SELECT = 4'h2;
    localparam logic [1:0] FACTORY_STARTUP      = 2'h2;
    localparam logic       FACTORY_DIV8         = 1'h0;

    // register byte offsets
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] OPTION_OFFSET = 8'h08;

    // control register fields and reset value
    localparam int unsigned CTRL_MODE_LSB  = 0;
    localparam int unsigned CTRL_SLEEP_BIT = 3;
    localparam logic [2:0]  CTRL_RESET     = 3'h0;

    // status register fields
    localparam int unsigned STAT_STATE_LSB  = 0;
    localparam int unsigned STAT_SOURCE_LSB = 4;
    localparam int unsigned STAT_OPTERR_BIT = 6;
    localparam int unsigned STAT_DIV8_BIT   = 7;
    localparam int unsigned STAT_MODE_LSB   = 8;
    localparam int unsigned STAT_EN_LSB     = 12;

    // option register fields
    localparam int unsigned OPT_SEL_LSB  = 0;
    localparam int unsigned OPT_SUT_LSB  = 4;
    localparam int unsigned OPT_DIV8_BIT = 6;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HRESP_OKAY    = 2'h0;

    typedef enum logic [1:0] {
        SRC_CRYSTAL = 2'b00,
        SRC_LOWFREQ = 2'b01,
        SRC_RC      = 2'b10,
        SRC_EXT     = 2'b11
    } csc_source_t;

    typedef enum logic [2:0] {
        ST_LATCH   = 3'b000,
        ST_RST_SRC = 3'b001,
        ST_RST_WDT = 3'b010,
        ST_RUN     = 3'b011,
        ST_SLEEP   = 3'b100,
        ST_WAKE    = 3'b101
    } csc_state_t;

    typedef enum logic [2:0] {
        SLP_IDLE      = 3'b000,
        SLP_ADC_NOISE = 3'b001,
        SLP_PDOWN     = 3'b010,
        SLP_PSAVE     = 3'b011,
        SLP_STANDBY   = 3'b110
    } csc_sleep_t;

endpackage

`default_nettype wire

// ---- hw/csc_cycle_counter.sv ----
// counts enable ticks up to a target and holds done until restarted
// target held stable while counting; zero target done at once
`default_nettype none

module csc_cycle_counter #(
    parameter int unsigned WIDTH = 17
) (
    // clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // control
    input  wire logic             start,
    input  wire logic             tick,
    input  wire logic [WIDTH-1:0] target,
    // result
    output logic                  done
);
    import csc_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic             busy;
        logic             done;
    } csc_cnt_state_t;

    csc_cnt_state_t s;
    csc_cnt_state_t next_s;

    if (WIDTH < 2) begin : g_bad_width
        $error("counter width too small");
    end

    always_comb begin
        next_s = s;
        if (start) begin
            next_s.count = '0;
            next_s.busy  = (target != '0);
            next_s.done  = (target == '0);
        end else if (s.busy && tick) begin
            next_s.count = s.count + WIDTH'(1);
            if (s.count + WIDTH'(1) == target) begin
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign done = s.done;

endmodule

`default_nettype wire

// ---- hw/csc_ahb_regs.sv ----
// ahb-lite slave for the control, status and option registers
// assumes single word transfers; zero wait states, always okay
`default_nettype none

module csc_ahb_regs (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic      [1:0]  hresp,
    // block side
    input  wire logic [31:0] status_word,
    input  wire logic [31:0] option_word,
    output logic      [2:0]  sleep_mode,
    output logic             sleep_req
);
    import csc_pkg::*;

    typedef struct packed {
        logic        wr_pending;
        logic [7:0]  wr_addr;
        logic [2:0]  mode;
        logic        sleep_req;
        logic [31:0] rdata;
    } csc_bus_state_t;

    csc_bus_state_t s;
    csc_bus_state_t next_s;
    logic           take;
    logic           mapped;

    always_comb begin
        take   = hsel && hready && htrans[1];
        mapped = (haddr[31:8] == 24'h000000);
        next_s           = s;
        next_s.sleep_req = 1'b0;
        next_s.wr_pending = take && hwrite && mapped;
        next_s.wr_addr   = haddr[7:0];
        // data phase of a write
        if (s.wr_pending && s.wr_addr == CTRL_OFFSET) begin
            next_s.mode      = hwdata[CTRL_MODE_LSB +: 3];
            next_s.sleep_req = hwdata[CTRL_SLEEP_BIT];
        end
        // read address phase: capture for data phase
        if (take && !hwrite) begin
            next_s.rdata = 32'h00000000;
            if (mapped) begin
                unique case (haddr[7:0])
                    CTRL_OFFSET:   next_s.rdata[CTRL_MODE_LSB +: 3] = s.mode;
                    STATUS_OFFSET: next_s.rdata = status_word;
                    OPTION_OFFSET: next_s.rdata = option_word;
                    default:       next_s.rdata = 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s      <= '0;
            s.mode <= CTRL_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign hrdata     = s.rdata;
    assign hreadyout  = 1'b1;
    assign hresp      = HRESP_OKAY;
    assign sleep_mode = s.mode;
    assign sleep_req  = s.sleep_req;

endmodule

`default_nettype wire

// ---- hw/csc_clock_control.sv ----
// clock source decode, start-up timing and clock domain gating
// assumes source, watchdog and async oscillator edges arrive as one-cycle
// ticks synchronous to hclk; wake_event comes from asynchronous wake logic
//
// Operation
// - clock select codes: 1xxx crystal, 011x low-freq, 0010 rc, 0000 external
// - option bits inverted: stored one unprogrammed, stored zero programmed
// - wake from power-down or power-save counts source start-up before execution
// - reset adds settling delay counted on watchdog oscillator after source count
// - settling delay is 0, 4096 or 65536 watchdog oscillator cycles
// - factory default: rc code 0010, start-up option 10, divide by eight
// - crystal frequency mode from upper three select bits: 100 to 111
// - crystal wake count 258, 1K or 16K from low bit and start-up option
// - crystal reset delay 14 cycles plus optional 4.1 ms or 65 ms
// - sleep modes stop clocks of unused modules
// - core clock stopped halts all core operation
// - peripheral clock drives timers; some external interrupts wake asynchronously
// - serial start detection works asynchronously in every sleep mode
// - memory interface clock gated together with core clock
// - asynchronous timer domain keeps running while device sleeps
// - converter clock runs in adc noise mode while core and peripheral clocks stop; power-down, power-save and standby stop it too
// - low-frequency crystal wake count 1K for 0110, 32K for 0111
// - rc and external wake count 6; reset 14 plus option delay
`default_nettype none

module csc_clock_control #(
    parameter int unsigned WDT_SHORT = csc_pkg::WDT_SHORT_CYCLES,
    parameter int unsigned WDT_LONG  = csc_pkg::WDT_LONG_CYCLES,
    parameter int unsigned WAKE_16K  = csc_pkg::CK_WAKE_16K,
    parameter int unsigned WAKE_32K  = csc_pkg::CK_WAKE_32K
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic      [1:0]  hresp,
    // non-volatile option bits, stored sense
    input  wire logic [3:0]  clock_source_select_option,
    input  wire logic [1:0]  startup_time_option,
    input  wire logic        divide_by_eight_option,
    input  wire logic        option_valid,
    // oscillator ticks and wake
    input  wire logic        source_tick,
    input  wire logic        watchdog_oscillator_tick,
    input  wire logic        async_tick,
    input  wire logic        wake_event,
    // oscillator configuration
    output logic      [1:0]  oscillator_kind,
    output logic      [2:0]  crystal_frequency_mode_bits,
    // reset and clock domain enables
    output logic             internal_reset_n,
    output logic             core_clock_en,
    output logic             flash_clock_en,
    output logic             io_clock_en,
    output logic             async_clock_en,
    output logic             adc_clock_en
);
    import csc_pkg::*;

    typedef struct packed {
        csc_state_t  state;
        logic [2:0]  prescale;
        logic [3:0]  opt_sel;
        logic [1:0]  opt_sut;
        logic        opt_div8;
        logic        opt_err;
        csc_source_t source;
        csc_sleep_t  mode;
        logic        src_start;
        logic        wdt_start;
        logic        reset_n;
        logic [4:0]  en;
    } csc_ctl_state_t;

    csc_ctl_state_t   s;
    csc_ctl_state_t   next_s;
    logic             src_done;
    logic             wdt_done;
    logic [CNT_W-1:0] src_target;
    logic [CNT_W-1:0] wdt_target;
    logic [31:0]      status_word;
    logic [31:0]      option_word;
    logic [2:0]       bus_mode;
    logic             sleep_req;
    logic             div8_on;
    logic             sys_tick;
    logic             mode_idle;
    logic             mode_adc;

    if (WDT_SHORT == 0 || WDT_LONG >= (1 << CNT_W) || WDT_SHORT > WDT_LONG
        || WAKE_16K < CK_WAKE_1K || WAKE_32K >= (1 << CNT_W)) begin : g_bad_counts
        $error("start-up counts out of range");
    end

    // source kind; reserved codes flagged
    function automatic logic [2:0] decode_source(input logic [3:0] sel);
        logic [2:0] r;
        if (sel[3]) begin
            r = {1'b0, SRC_CRYSTAL};
        end else if (sel == SEL_LOWFREQ_FAST || sel == SEL_LOWFREQ_SLOW) begin
            r = {1'b0, SRC_LOWFREQ};
        end else if (sel == SEL_RC) begin
            r = {1'b0, SRC_RC};
        end else if (sel == SEL_EXT) begin
            r = {1'b0, SRC_EXT};
        end else begin
            r = {1'b1, SRC_RC};
        end
        return r;
    endfunction

    // source cycles counted on wake
    function automatic logic [CNT_W-1:0] wake_count(input logic [3:0] sel,
                                                    input logic [1:0] sut);
        logic [CNT_W-1:0] r;
        r = CNT_W'(CK_WAKE_RC_EXT);
        if (sel[3]) begin
            if (!sel[0] && !sut[1]) begin
                r = CNT_W'(CK_WAKE_258);
            end else if (!sel[0] || sut == 2'h0) begin
                r = CNT_W'(CK_WAKE_1K);
            end else begin
                r = CNT_W'(WAKE_16K);
            end
        end else if (sel == SEL_LOWFREQ_FAST) begin
            r = CNT_W'(CK_WAKE_1K);
        end else if (sel == SEL_LOWFREQ_SLOW) begin
            r = CNT_W'(WAKE_32K);
        end
        return r;
    endfunction

    // watchdog cycles added after the 14-cycle reset count
    function automatic logic [CNT_W-1:0] settle_count(input logic [3:0] sel,
                                                      input logic [1:0] sut);
        logic [CNT_W-1:0] r;
        logic [2:0]       idx;
        idx = {sel[0], sut};
        if (sel[3]) begin
            unique case (idx)
                3'h0, 3'h3, 3'h6: r = CNT_W'(WDT_SHORT);
                3'h1, 3'h4, 3'h7: r = CNT_W'(WDT_LONG);
                3'h2, 3'h5:       r = '0;
            endcase
        end else begin
            unique case (sut)
                2'h0: r = '0;
                2'h1: r = CNT_W'(WDT_SHORT);
                2'h2: r = CNT_W'(WDT_LONG);
                2'h3: r = CNT_W'(WDT_LONG);
            endcase
        end
        return r;
    endfunction

    // system tick, divided by eight when programmed
    always_comb begin
        div8_on   = !s.opt_div8;
        sys_tick  = source_tick && (!div8_on || s.prescale == 3'(PRESCALE_DIV8_TOP));
        mode_idle = (s.state == ST_SLEEP) && (s.mode == SLP_IDLE);
        mode_adc  = (s.state == ST_SLEEP) && (s.mode == SLP_ADC_NOISE);
    end

    always_comb begin
        src_target = (s.state == ST_RST_SRC) ? CNT_W'(CK_RESET_SRC)
                                             : wake_count(s.opt_sel, s.opt_sut);
        wdt_target = settle_count(s.opt_sel, s.opt_sut);
    end

    always_comb begin
        logic [2:0] dec;
        dec              = 3'h0;
        next_s           = s;
        next_s.src_start = 1'b0;
        next_s.wdt_start = 1'b0;
        if (source_tick && div8_on) begin
            next_s.prescale = s.prescale + 3'h1;
        end
        unique case (s.state)
            ST_LATCH: begin
                if (option_valid) begin
                    next_s.opt_sel  = clock_source_select_option;
                    next_s.opt_sut  = startup_time_option;
                    next_s.opt_div8 = divide_by_eight_option;
                    dec             = decode_source(clock_source_select_option);
                end else begin
                    next_s.opt_sel  = FACTORY_CLOCK_SELECT;
                    next_s.opt_sut  = FACTORY_STARTUP;
                    next_s.opt_div8 = FACTORY_DIV8;
                    dec             = decode_source(FACTORY_CLOCK_SELECT);
                end
                // reserved codes fall back to rc
                if (dec[2]) begin
                    next_s.opt_sel = FACTORY_CLOCK_SELECT;
                end
                next_s.opt_err   = dec[2];
                next_s.source    = csc_source_t'(dec[1:0]);
                next_s.state     = ST_RST_SRC;
                next_s.src_start = 1'b1;
            end
            ST_RST_SRC: begin
                if (src_done && !s.src_start) begin
                    next_s.state     = ST_RST_WDT;
                    next_s.wdt_start = 1'b1;
                end
            end
            ST_RST_WDT: begin
                if (wdt_done && !s.wdt_start) begin
                    next_s.state   = ST_RUN;
                    next_s.reset_n = 1'b1;
                end
            end
            ST_RUN: begin
                if (sleep_req) begin
                    next_s.state = ST_SLEEP;
                    next_s.mode  = csc_sleep_t'(bus_mode);
                    if (bus_mode != SLP_ADC_NOISE && bus_mode != SLP_PDOWN
                        && bus_mode != SLP_PSAVE && bus_mode != SLP_STANDBY) begin
                        next_s.mode = SLP_IDLE;
                    end
                end
            end
            ST_SLEEP: begin
                // wake is taken without the io clock
                if (wake_event) begin
                    if (s.mode == SLP_PDOWN || s.mode == SLP_PSAVE) begin
                        next_s.state     = ST_WAKE;
                        next_s.src_start = 1'b1;
                    end else begin
                        next_s.state = ST_RUN;
                    end
                end
            end
            ST_WAKE: begin
                if (src_done && !s.src_start) begin
                    next_s.state = ST_RUN;
                end
            end
            default: begin
                next_s.state = ST_LATCH;
            end
        endcase
        // domain enables: core, flash, io, async, adc
        next_s.en[0] = sys_tick && (s.state == ST_RUN);
        next_s.en[1] = sys_tick && (s.state == ST_RUN);
        next_s.en[2] = sys_tick && (s.state == ST_RUN || mode_idle);
        next_s.en[3] = async_tick && s.reset_n;
        next_s.en[4] = sys_tick && (s.state == ST_RUN || mode_idle || mode_adc);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s        <= '0;
            s.source <= SRC_RC;
        end else begin
            s <= next_s;
        end
    end

    csc_cycle_counter #(
        .WIDTH (CNT_W)
    ) u_source_counter (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (s.src_start),
        .tick    (source_tick),
        .target  (src_target),
        .done    (src_done)
    );

    csc_cycle_counter #(
        .WIDTH (CNT_W)
    ) u_watchdog_counter (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (s.wdt_start),
        .tick    (watchdog_oscillator_tick),
        .target  (wdt_target),
        .done    (wdt_done)
    );

    always_comb begin
        status_word = 32'h00000000;
        status_word[STAT_STATE_LSB +: 3]  = s.state;
        status_word[STAT_SOURCE_LSB +: 2] = s.source;
        status_word[STAT_OPTERR_BIT]      = s.opt_err;
        status_word[STAT_DIV8_BIT]        = div8_on;
        status_word[STAT_MODE_LSB +: 3]   = s.mode;
        status_word[STAT_EN_LSB +: 5]     = s.en;
        option_word = 32'h00000000;
        option_word[OPT_SEL_LSB +: 4] = s.opt_sel;
        option_word[OPT_SUT_LSB +: 2] = s.opt_sut;
        option_word[OPT_DIV8_BIT]     = s.opt_div8;
    end

    csc_ahb_regs u_regs (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .hsel        (hsel),
        .haddr       (haddr),
        .htrans      (htrans),
        .hwrite      (hwrite),
        .hsize       (hsize),
        .hwdata      (hwdata),
        .hready      (hready),
        .hrdata      (hrdata),
        .hreadyout   (hreadyout),
        .hresp       (hresp),
        .status_word (status_word),
        .option_word (option_word),
        .sleep_mode  (bus_mode),
        .sleep_req   (sleep_req)
    );

    assign oscillator_kind             = s.source;
    assign crystal_frequency_mode_bits = (s.source == SRC_CRYSTAL) ? s.opt_sel[3:1]
                                                                   : 3'h0;
    assign internal_reset_n = s.reset_n;
    assign core_clock_en    = s.en[0];
    assign flash_clock_en   = s.en[1];
    assign io_clock_en      = s.en[2];
    assign async_clock_en   = s.en[3];
    assign adc_clock_en     = s.en[4];

endmodule

`default_nettype wire

// ---- testbench/csc_osc_model.sv ----
// oscillator model: source, watchdog and async ticks
// assumes ticks are one-cycle pulses in the hclk domain
`default_nettype none
module csc_osc_model (
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // source tick spacing minus one
    input  wire logic [3:0] src_gap,
    // oscillator ticks
    output logic            source_tick,
    output logic            watchdog_oscillator_tick,
    output logic            async_tick
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] n_src;
    logic [2:0] n_wd;
    logic [2:0] n_as;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            n_src <= 4'h0;
            n_wd <= 3'h0;
            n_as <= 3'h0;
        end else begin
            n_src <= (n_src >= src_gap) ? 4'h0 : n_src + 4'h1;
            n_wd <= (n_wd == 3'h2) ? 3'h0 : n_wd + 3'h1;
            n_as <= (n_as == 3'h4) ? 3'h0 : n_as + 3'h1;
        end
    end
    // watchdog slower, async slowest
    assign source_tick = (n_src == src_gap);
    assign watchdog_oscillator_tick = (n_wd == 3'h2);
    assign async_tick = (n_as == 3'h4);
endmodule
`default_nettype wire

// ---- testbench/csc_properties.sv ----
// checker on the clock control outputs
// assumes only the ports of the top module
`default_nettype none
module csc_chk (
    // clock and reset
    input wire logic       hclk,
    input wire logic       hresetn,
    // watched signals
    input wire logic       source_tick,
    input wire logic       async_tick,
    input wire logic [1:0] oscillator_kind,
    input wire logic [2:0] crystal_frequency_mode_bits,
    input wire logic       internal_reset_n,
    input wire logic       core_clock_en,
    input wire logic       flash_clock_en,
    input wire logic       io_clock_en,
    input wire logic       async_clock_en
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [7:0] n_src;
    // source ticks seen while held in reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            n_src <= 8'h00;
        end else if (!internal_reset_n && source_tick && n_src != 8'hff) begin
            n_src <= n_src + 8'h01;
        end
    end
    a_reset_count: assert property ($rose(internal_reset_n) |-> n_src >= 8'h0e)
        else $error("early reset release");
    a_reset_holds: assert property (internal_reset_n |=> internal_reset_n)
        else $error("reset fell");
    a_en_in_reset: assert property (!internal_reset_n |-> !(core_clock_en || io_clock_en))
        else $error("enable in reset");
    a_flash_core: assert property (flash_clock_en == core_clock_en)
        else $error("flash vs core");
    a_core_tick: assert property (core_clock_en |-> $past(source_tick))
        else $error("core without tick");
    a_async_copy: assert property (internal_reset_n |=> async_clock_en == $past(async_tick))
        else $error("async copy");
    a_kind_fixed: assert property (internal_reset_n |-> $stable(oscillator_kind))
        else $error("kind changed");
    a_mode_bits: assert property (crystal_frequency_mode_bits[2] == (oscillator_kind == 2'h0))
        else $error("mode bits");
endmodule
bind csc_clock_control csc_chk u_chk (.*);
`default_nettype wire

// ---- testbench/csc_clock_control_tb.sv ----
// bench for the clock source and start-up control
// assumes the oscillator model and the bound checker
`default_nettype none
module csc_clock_control_tb;
    import csc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, option_valid = 1'b0;
    logic        div8 = 1'b1, wake_event = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [1:0]  htrans = 2'h0, sut = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [3:0]  sel = 4'h2;
    wire logic [31:0] hrdata;
    wire logic [2:0]  xmode;
    wire logic [1:0]  hresp, kind;
    wire logic        hreadyout, source_tick, watchdog_oscillator_tick, async_tick, rst_n;
    wire logic        core_en, flash_en, io_en, async_en, adc_en;
    int               num_errors = 0, n_tests = 0, cyc = 0;
    csc_clock_control #(.WDT_SHORT(20), .WDT_LONG(40), .WAKE_16K(1024), .WAKE_32K(40)) u_dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .clock_source_select_option(sel), .startup_time_option(sut),
        .divide_by_eight_option(div8), .option_valid, .source_tick,
        .watchdog_oscillator_tick, .async_tick, .wake_event,
        .oscillator_kind(kind), .crystal_frequency_mode_bits(xmode),
        .internal_reset_n(rst_n), .core_clock_en(core_en), .flash_clock_en(flash_en),
        .io_clock_en(io_en), .async_clock_en(async_en), .adc_clock_en(adc_en));
    csc_osc_model u_osc (.hclk, .hresetn, .src_gap(4'h1), .source_tick,
        .watchdog_oscillator_tick, .async_tick);
    initial begin
        forever #20 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d = 32'h0);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic boot(input logic [3:0] s, input logic [1:0] u, input logic d, input logic v,
                        input logic [1:0] k, input int w);
        int   ns = 0, nw = 0;
        logic r;
        r = (k == 2'h2) && (s != SEL_RC);
        @(posedge hclk);
        hresetn <= 1'b0;
        option_valid <= v;
        sel <= v ? s : ~s;
        sut <= v ? u : ~u;
        div8 <= v ? d : ~d;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        while (rst_n !== 1'b1) begin
            @(negedge hclk);
            ns += 32'(source_tick);
            nw += 32'(watchdog_oscillator_tick);
        end
        chk("src ticks", 32'h1, 32'(ns >= CK_RESET_SRC));
        chk("wdt ticks", 32'h1, 32'(nw >= w && nw <= w + 12));
        chk("kind", 32'(k), 32'(kind));
        chk("xtal mode", (k == 2'h0) ? 32'(s[3:1]) : 32'h0, 32'(xmode));
        bus(1'b0, 32'(OPTION_OFFSET));
        chk("option", {25'h0, d, u, r ? SEL_RC : s}, rd);
        bus(1'b0, 32'(STATUS_OFFSET));
        chk("status", 32'({~d, r, k, 4'h3}), 32'({rd[7:4], 1'b0, rd[2:0]}));
        $display("test boot %h done", s);
    endtask
    task automatic nap(input logic [2:0] m, input logic io, input logic adc, input int lo);
        int nc = 0, ni = 0, na = 0, ny = 0, ns = 0;
        bus(1'b1, 32'(CTRL_OFFSET), {28'h0, 1'b1, m});
        repeat (3) @(posedge hclk);
        bus(1'b0, 32'(STATUS_OFFSET));
        chk("sleep state", 32'(ST_SLEEP), 32'(rd[2:0]));
        repeat (16) begin
            @(negedge hclk);
            nc += 32'(core_en | flash_en);
            ni += 32'(io_en);
            na += 32'(adc_en);
            ny += 32'(async_en);
        end
        chk("core off", 32'h0, 32'(nc));
        chk("io", 32'(io), 32'(ni > 0));
        chk("adc", 32'(adc), 32'(na > 0));
        chk("async", 32'h1, 32'(ny > 0));
        @(posedge hclk);
        wake_event <= 1'b1;
        @(posedge hclk);
        wake_event <= 1'b0;
        while (core_en !== 1'b1) begin
            @(negedge hclk);
            ns += 32'(source_tick);
        end
        chk("wake ticks", 32'h1, 32'(ns >= lo && ns <= lo + 4));
        $display("test sleep %0d done", m);
    endtask
    initial begin
        boot(FACTORY_CLOCK_SELECT, FACTORY_STARTUP, FACTORY_DIV8, 1'b0, 2'h2, 40);
        boot(4'h9, 2'h1, 1'b1, 1'b1, 2'h0, 0);
        boot(4'he, 2'h0, 1'b1, 1'b1, 2'h0, 20);
        boot(4'h7, 2'h2, 1'b1, 1'b1, 2'h1, 40);
        boot(4'h0, 2'h1, 1'b1, 1'b1, 2'h3, 20);
        boot(4'h3, 2'h0, 1'b1, 1'b1, 2'h2, 0);
        bus(1'b0, 32'h0000_0100);
        chk("unmapped", 32'h0, rd);
        nap(SLP_IDLE, 1'b1, 1'b1, 0);
        nap(SLP_ADC_NOISE, 1'b0, 1'b1, 0);
        nap(SLP_PDOWN, 1'b0, 1'b0, 6);
        nap(SLP_PSAVE, 1'b0, 1'b0, 6);
        nap(SLP_STANDBY, 1'b0, 1'b0, 0);
        close_out();
    end
endmodule
`default_nettype wire
